// *** shared/pmw_pkg.sv ***
// constants for the operating-mode and wake-up controller
// assumes an APB master on mclk, oscillators and port pins outside this clock domain
// Operation
// [R01] writing 111 to the clock select while fast moves the system to the sub clock
// [R02] the switch to slow completes only once the low-speed oscillator is stable
// [R03] writing 000 to 110 while slow selects the high-speed clock divided 1 to 64
// [R04] return to fast waits for high-speed restart; software may poll the stable flag
// [R05] halt with both keep bits 0 enters sleep; only the watchdog keeps going
// [R06] halt with hs keep 0, ls keep 1 stops high-speed, keeps sub clock
// [R07] halt with both keep bits 1 keeps both clocks, program stopped
// [R08] halt with hs keep 1, ls keep 0 keeps high-speed, stops sub clock
// [R09] entering a halted mode leaves memory, registers and ports untouched
// [R10] halt entry sets the power-down flag and clears the time-out flag
// [R11] halt entry clears the watchdog counter; it counts on only if enabled
// [R12] wake from port A falling edge, a system interrupt or a watchdog overflow
// [R13] power-down flag clears only at power-up or on the clear-watchdog instruction
// [R14] watchdog overflow while halted sets time-out, resets only program counter and stack
// [R15] each port A pin has its own wake enable; resume after the halt
// [R16] disabled or stack-full interrupt wake resumes after halt; request stays pending
// [R17] enabled interrupt wake with stack room gets the normal interrupt response
// [R18] an interrupt already requested before halt cannot wake the device
// [R19] watchdog runs from the low-speed clock divided by 2^8 to 2^15
// [R20] clock select codes 000 to 110 give divide 1 to 64, 111 the sub clock
// [R21] enabling the high-speed oscillator shows stable 0 first, then 1 once settled
// [R22] each keep bit decides if its oscillator runs while the cpu is halted; the low-speed oscillator also runs while the watchdog is enabled
// [R23] after wake the selected clock restarts and the cpu waits until it is stable
package pmw_pkg;
  localparam int PMW_AW = 5;
  localparam logic [PMW_AW-1:0] PMW_SYSCTL_ADDR = 5'h00;
  localparam logic [PMW_AW-1:0] PMW_OSCCTL_ADDR = 5'h04;
  localparam logic [PMW_AW-1:0] PMW_WDTCTL_ADDR = 5'h08;
  localparam logic [PMW_AW-1:0] PMW_STATUS_ADDR = 5'h0C;
  localparam logic [PMW_AW-1:0] PMW_WAKEEN_ADDR = 5'h10;
  // field positions
  localparam int PMW_SEL_LSB = 5;
  localparam int PMW_SEL_MSB = 7;
  localparam int PMW_HSKEEP_BIT = 1;
  localparam int PMW_LSKEEP_BIT = 0;
  localparam int PMW_HSSTABLE_BIT = 1;
  localparam int PMW_HSEN_BIT = 0;
  localparam int PMW_WDTEN_BIT = 3;
  localparam int PMW_WDTPER_LSB = 0;
  localparam int PMW_WDTPER_MSB = 2;
  localparam int PMW_PDF_BIT = 0;
  localparam int PMW_TO_BIT = 1;
  localparam int PMW_MODE_LSB = 4;
  localparam int PMW_MODE_MSB = 6;
  // codes and reset values
  localparam logic [2:0] PMW_SEL_SUB = 3'h7;
  localparam logic [2:0] PMW_SEL_RST = 3'h0;
  localparam logic [2:0] PMW_WDTPER_RST = 3'h3;
  localparam int PMW_WDT_BASE_SHIFT = 8;
  localparam int PMW_WDT_W = 15;
  localparam int PMW_NPIN = 8;
  localparam int PMW_NIRQ = 8;
  // mode readback codes
  localparam logic [2:0] PMW_MODE_FAST = 3'h0;
  localparam logic [2:0] PMW_MODE_SLOW = 3'h1;
  localparam logic [2:0] PMW_MODE_SLEEP = 3'h2;
  localparam logic [2:0] PMW_MODE_IDLE_SUB_ONLY = 3'h3;
  localparam logic [2:0] PMW_MODE_IDLE_BOTH_CLOCKS = 3'h4;
  localparam logic [2:0] PMW_MODE_IDLE_HS_ONLY = 3'h5;
  localparam logic [2:0] PMW_MODE_SWITCH = 3'h6;

  typedef enum logic [4:0] {
    PMW_ST_RUN = 5'b0_0001,
    PMW_ST_TOSLOW = 5'b0_0010,
    PMW_ST_TOFAST = 5'b0_0100,
    PMW_ST_HALT = 5'b0_1000,
    PMW_ST_WAKE = 5'b1_0000
  } pmw_state_t;
endpackage

// *** src/pmw_power_mode_wakeup_control.sv ***
// operating-mode, clock-switch, halt and wake-up controller with watchdog counter
// assumes a cpu core on mclk giving halt and clear-watchdog pulses, and
// oscillator ready levels, watchdog source clock and port pins from other domains
module pmw_power_mode_wakeup_control
  import pmw_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltExec,
  input wire logic clearWatchdogInstruction,
  input wire logic [PMW_NPIN-1:0] portAPin,
  input wire logic [PMW_NIRQ-1:0] irqRequest,
  input wire logic [PMW_NIRQ-1:0] irqEnable,
  input wire logic stackFull,
  input wire logic highSpeedOscReady,
  input wire logic lowSpeedOscReady,
  input wire logic wdtSourceClock,
  output logic highSpeedOscEn,
  output logic lowSpeedOscEn,
  output logic subClkEn,
  output logic [2:0] sysClkSelect,
  output logic cpuRun,
  output logic pcSpReset,
  output logic irqServe,
  output logic resumeAfterHalt,
  output logic wdtChipReset
);

  ////////////////////////////////////////////////////////////////
  // synchronisers
  logic [PMW_NPIN-1:0] pinMeta_r, pinSync_r, pinPrev_r;
  logic [2:0] rdyMeta_r, rdySync_r;
  logic wdtPrev_r;
  logic hsReady, lsReady, wdtSrcSync;

  always_ff @(posedge mclk) begin
    pinMeta_r <= portAPin;
    pinSync_r <= pinMeta_r;
    pinPrev_r <= pinSync_r;
    rdyMeta_r <= {wdtSourceClock, lowSpeedOscReady, highSpeedOscReady};
    rdySync_r <= rdyMeta_r;
    wdtPrev_r <= rdySync_r[2];
  end

  assign hsReady = rdySync_r[0];
  assign lsReady = rdySync_r[1];
  assign wdtSrcSync = rdySync_r[2];

  ////////////////////////////////////////////////////////////////
  // state and registers
  pmw_state_t state_r;
  logic [2:0] selReq_r;
  logic [2:0] sysClkSel_r;
  logic hsKeep_r, lsKeep_r, hsEnCtl_r;
  logic wdtEn_r;
  logic [2:0] wdtPer_r;
  logic powerDownFlag_r, watchdogTimeoutFlag_r;
  logic [PMW_NPIN-1:0] portAWakeEnable_r;
  logic [PMW_NIRQ-1:0] irqPreset_r;
  logic [PMW_WDT_W-1:0] wdtCnt_r;
  logic apbWr, apbRd, apbDone, addrHit;
  logic haltGo, wdtTick, wdtOvf;
  logic pinWake, irqWake, anyWake;
  logic [PMW_NIRQ-1:0] irqNew;
  logic selIsSub, curIsSub, hsStableFlag, targetStable;
  logic [2:0] modeCode;

  assign apbDone = psel & penable & pready;
  assign apbWr = apbDone & pwrite;
  assign apbRd = psel & penable & ~pready & ~pwrite;
  assign addrHit = paddr[PMW_AW-1:0] == PMW_SYSCTL_ADDR ||
                   paddr[PMW_AW-1:0] == PMW_OSCCTL_ADDR ||
                   paddr[PMW_AW-1:0] == PMW_WDTCTL_ADDR ||
                   paddr[PMW_AW-1:0] == PMW_STATUS_ADDR ||
                   paddr[PMW_AW-1:0] == PMW_WAKEEN_ADDR;
  assign selIsSub = selReq_r == PMW_SEL_SUB; // [R20]
  assign curIsSub = sysClkSel_r == PMW_SEL_SUB;
  assign hsStableFlag = hsEnCtl_r & hsReady; // [R21]
  assign haltGo = haltExec & (state_r == PMW_ST_RUN);
  assign wdtTick = wdtSrcSync & ~wdtPrev_r;

  // overflow when the counter reaches 2^(8+period)-1
  function automatic logic wdtAtLimit(input logic [PMW_WDT_W-1:0] cnt, input logic [2:0] per);
    logic [PMW_WDT_W-1:0] lim;
    lim = PMW_WDT_W'((32'd1 << (PMW_WDT_BASE_SHIFT + int'(per))) - 32'd1);
    return cnt == lim;
  endfunction

  assign wdtOvf = wdtEn_r & wdtTick & wdtAtLimit(wdtCnt_r, wdtPer_r); // [R19]

  // an interrupt already pending at halt entry is masked out
  assign irqNew = irqRequest & ~irqPreset_r; // [R18]
  assign pinWake = |(~pinSync_r & pinPrev_r & portAWakeEnable_r); // [R15]
  assign irqWake = |irqNew;
  assign anyWake = pinWake | irqWake | wdtOvf; // [R12]
  // hs oscillator is forced on while fast, so a cleared enable bit must not stall the wake
  assign targetStable = curIsSub ? lsReady : hsReady; // [R23]

  ////////////////////////////////////////////////////////////////
  // mode state machine
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= PMW_ST_RUN;
    end else begin
      unique case (state_r)
        PMW_ST_RUN: begin
          if (haltGo) begin
            state_r <= PMW_ST_HALT; // [R05] [R06] [R07] [R08]
          end else if (selReq_r != sysClkSel_r && selIsSub && !curIsSub) begin
            state_r <= PMW_ST_TOSLOW; // [R01]
          end else if (selReq_r != sysClkSel_r && !selIsSub && curIsSub) begin
            state_r <= PMW_ST_TOFAST; // [R03]
          end
        end
        PMW_ST_TOSLOW: begin
          if (lsReady) begin
            state_r <= PMW_ST_RUN; // [R02]
          end
        end
        PMW_ST_TOFAST: begin
          if (hsReady) begin
            state_r <= PMW_ST_RUN; // [R04]
          end
        end
        PMW_ST_HALT: begin
          if (anyWake) begin
            state_r <= PMW_ST_WAKE;
          end
        end
        PMW_ST_WAKE: begin
          if (targetStable) begin
            state_r <= PMW_ST_RUN; // [R23]
          end
        end
      endcase
    end
  end

  // applied system clock select; divide changes inside fast mode are immediate
  always_ff @(posedge mclk) begin
    if (srst) begin
      sysClkSel_r <= PMW_SEL_RST;
    end else if (state_r == PMW_ST_RUN && !selIsSub && !curIsSub) begin
      sysClkSel_r <= selReq_r; // [R20]
    end else if (state_r == PMW_ST_TOSLOW && lsReady) begin
      sysClkSel_r <= PMW_SEL_SUB; // [R01] [R02]
    end else if (state_r == PMW_ST_TOFAST && hsReady) begin
      sysClkSel_r <= selReq_r; // [R03] [R04]
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers; APB writes are taken in every state, halted included
  always_ff @(posedge mclk) begin
    if (srst) begin
      selReq_r <= PMW_SEL_RST;
      hsKeep_r <= 1'b0;
      lsKeep_r <= 1'b0;
      hsEnCtl_r <= 1'b1;
      wdtEn_r <= 1'b1;
      wdtPer_r <= PMW_WDTPER_RST;
      portAWakeEnable_r <= '0;
    end else if (apbWr) begin // [R09]
      unique case (paddr[PMW_AW-1:0])
        PMW_SYSCTL_ADDR: begin
          selReq_r <= pwdata[PMW_SEL_MSB:PMW_SEL_LSB];
          hsKeep_r <= pwdata[PMW_HSKEEP_BIT]; // [R22]
          lsKeep_r <= pwdata[PMW_LSKEEP_BIT]; // [R22]
        end
        PMW_OSCCTL_ADDR: begin
          hsEnCtl_r <= pwdata[PMW_HSEN_BIT];
        end
        PMW_WDTCTL_ADDR: begin
          wdtEn_r <= pwdata[PMW_WDTEN_BIT];
          wdtPer_r <= pwdata[PMW_WDTPER_MSB:PMW_WDTPER_LSB];
        end
        PMW_WAKEEN_ADDR: begin
          portAWakeEnable_r <= pwdata[PMW_NPIN-1:0]; // [R15]
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      powerDownFlag_r <= 1'b0; // [R13]
    end else if (haltGo) begin
      powerDownFlag_r <= 1'b1; // [R10]
    end else if (clearWatchdogInstruction) begin
      powerDownFlag_r <= 1'b0; // [R13]
    end
  end

  // overflow set beats the halt-entry clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      watchdogTimeoutFlag_r <= 1'b0;
    end else if (wdtOvf) begin
      watchdogTimeoutFlag_r <= 1'b1; // [R14]
    end else if (haltGo) begin
      watchdogTimeoutFlag_r <= 1'b0; // [R10]
    end
  end

  // requests seen at halt entry lose their wake-up ability
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqPreset_r <= '0;
    end else if (haltGo) begin
      irqPreset_r <= irqRequest; // [R18]
    end else if (state_r != PMW_ST_HALT) begin
      irqPreset_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // watchdog counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdtCnt_r <= '0;
    end else if (haltGo || clearWatchdogInstruction || wdtOvf) begin
      wdtCnt_r <= '0; // [R11]
    end else if (wdtEn_r && wdtTick) begin
      wdtCnt_r <= wdtCnt_r + 1'b1; // [R11] [R19]
    end
  end

  ////////////////////////////////////////////////////////////////
  // oscillator and clock gating
  always_ff @(posedge mclk) begin
    if (srst) begin
      highSpeedOscEn <= 1'b1;
      lowSpeedOscEn <= 1'b1;
      subClkEn <= 1'b1;
      cpuRun <= 1'b1;
    end else begin
      if (state_r == PMW_ST_HALT && !anyWake) begin
        highSpeedOscEn <= hsKeep_r; // [R05] [R06] [R07] [R08] [R22]
        subClkEn <= lsKeep_r; // [R05] [R06] [R07] [R08]
        lowSpeedOscEn <= lsKeep_r | wdtEn_r; // [R05] [R22]
        cpuRun <= 1'b0;
      end else begin
        // restart the selected source; fast modes and slow-to-fast need high speed
        highSpeedOscEn <= hsEnCtl_r | ~curIsSub | (state_r == PMW_ST_TOFAST); // [R04] [R23]
        subClkEn <= 1'b1;
        lowSpeedOscEn <= 1'b1;
        cpuRun <= (state_r == PMW_ST_RUN) || (state_r == PMW_ST_TOSLOW) ||
                  (state_r == PMW_ST_TOFAST) || (state_r == PMW_ST_WAKE && targetStable);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sysClkSelect <= PMW_SEL_RST;
    end else begin
      sysClkSelect <= sysClkSel_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // wake-up event pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      pcSpReset <= 1'b0;
      irqServe <= 1'b0;
      resumeAfterHalt <= 1'b0;
      wdtChipReset <= 1'b0;
    end else begin
      pcSpReset <= (state_r == PMW_ST_HALT) & wdtOvf; // [R14]
      wdtChipReset <= (state_r != PMW_ST_HALT) & wdtOvf;
      // the request is left pending outside; only the response is chosen here
      irqServe <= (state_r == PMW_ST_HALT) & ~wdtOvf &
                  (|(irqNew & irqEnable)) & ~stackFull; // [R17]
      resumeAfterHalt <= (state_r == PMW_ST_HALT) & ~wdtOvf & anyWake &
                         ~((|(irqNew & irqEnable)) & ~stackFull); // [R15] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then ready
  always_comb begin
    unique case (state_r)
      PMW_ST_RUN: modeCode = curIsSub ? PMW_MODE_SLOW : PMW_MODE_FAST;
      PMW_ST_HALT: modeCode = hsKeep_r ? (lsKeep_r ? PMW_MODE_IDLE_BOTH_CLOCKS : PMW_MODE_IDLE_HS_ONLY)
                                       : (lsKeep_r ? PMW_MODE_IDLE_SUB_ONLY : PMW_MODE_SLEEP);
      default: modeCode = PMW_MODE_SWITCH;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addrHit;
      prdata <= '0;
      if (apbRd) begin
        unique case (paddr[PMW_AW-1:0])
          PMW_SYSCTL_ADDR: begin
            prdata[PMW_SEL_MSB:PMW_SEL_LSB] <= selReq_r;
            prdata[PMW_HSKEEP_BIT] <= hsKeep_r;
            prdata[PMW_LSKEEP_BIT] <= lsKeep_r;
          end
          PMW_OSCCTL_ADDR: begin
            prdata[PMW_HSSTABLE_BIT] <= hsStableFlag; // [R04] [R21]
            prdata[PMW_HSEN_BIT] <= hsEnCtl_r;
          end
          PMW_WDTCTL_ADDR: begin
            prdata[PMW_WDTEN_BIT] <= wdtEn_r;
            prdata[PMW_WDTPER_MSB:PMW_WDTPER_LSB] <= wdtPer_r;
          end
          PMW_STATUS_ADDR: begin
            prdata[PMW_PDF_BIT] <= powerDownFlag_r;
            prdata[PMW_TO_BIT] <= watchdogTimeoutFlag_r;
            prdata[PMW_MODE_MSB:PMW_MODE_LSB] <= modeCode;
          end
          PMW_WAKEEN_ADDR: begin
            prdata[PMW_NPIN-1:0] <= portAWakeEnable_r;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

// *** sim/pmw_checker_assertions.sv ***
// checker for the mode and wake-up controller
// assumes binding onto the top module, one clock, synchronous reset
module pmw_checker
  import pmw_pkg::*;
(
  input logic mclk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic haltExec,
  input logic highSpeedOscReady,
  input logic lowSpeedOscReady,
  input logic highSpeedOscEn,
  input logic [2:0] sysClkSelect,
  input logic cpuRun,
  input logic pcSpReset,
  input logic irqServe,
  input logic resumeAfterHalt,
  input logic wdtChipReset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  sequence setupSeen;
    psel && !penable;
  endsequence
  sequence oneWait;
    !pready ##1 pready;
  endsequence
  sequence wakePulse;
    pcSpReset || irqServe || resumeAfterHalt;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_ready_wait: assert property (setupSeen |=> oneWait)
    else $error("pready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_halt_stops_cpu: assert property ($fell(cpuRun) |-> $past(haltExec, 2))
    else $error("cpu stopped without halt");
  a_wake_when_halted: assert property (wakePulse |-> !cpuRun)
    else $error("wake pulse while cpu runs");
  a_wake_one_kind: assert property (
    $onehot0({pcSpReset, irqServe, resumeAfterHalt, wdtChipReset}))
    else $error("two wake outcomes at once");
  // depths: two sync stages, then the applied select register and the output register
  a_sub_waits_ready: assert property (
    $changed(sysClkSelect) && sysClkSelect == PMW_SEL_SUB |-> $past(lowSpeedOscReady, 4))
    else $error("sub clock applied before ready");
  a_run_needs_hs: assert property (
    $rose(cpuRun) && sysClkSelect != PMW_SEL_SUB
      |-> highSpeedOscEn && $past(highSpeedOscReady, 3))
    else $error("cpu resumed before fast clock stable");
  a_fast_keeps_hs: assert property (
    cpuRun && sysClkSelect != PMW_SEL_SUB |-> highSpeedOscEn)
    else $error("fast clock running with oscillator off");
endmodule

bind pmw_power_mode_wakeup_control pmw_checker chk (.mclk, .srst, .psel, .penable,
  .prdata, .pready, .pslverr, .haltExec, .highSpeedOscReady, .lowSpeedOscReady,
  .highSpeedOscEn, .sysClkSelect, .cpuRun, .pcSpReset, .irqServe, .resumeAfterHalt,
  .wdtChipReset);

// *** sim/test_pmw_power_mode_wakeup_control.sv ***
// bench for the mode and wake-up controller
// assumes the design alone, its ports driven here directly
module test_pmw_power_mode_wakeup_control
  import pmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, haltExec = 0, clearWatchdogInstruction = 0;
  logic [7:0] portAPin = 8'hFF, irqRequest = '0, irqEnable = '0;
  logic stackFull = 0, highSpeedOscReady = 1, lowSpeedOscReady = 1, wdtSourceClock = 0;
  logic highSpeedOscEn, lowSpeedOscEn, subClkEn, cpuRun, pcSpReset, irqServe;
  logic resumeAfterHalt, wdtChipReset;
  logic [2:0] sysClkSelect, wdtDiv = '0;
  int badCount = 0, totalChecks = 0, nServe = 0, nResume = 0, nPcSp = 0;

  pmw_power_mode_wakeup_control dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .haltExec, .clearWatchdogInstruction, .portAPin,
    .irqRequest, .irqEnable, .stackFull, .highSpeedOscReady, .lowSpeedOscReady,
    .wdtSourceClock, .highSpeedOscEn, .lowSpeedOscEn, .subClkEn, .sysClkSelect, .cpuRun,
    .pcSpReset, .irqServe, .resumeAfterHalt, .wdtChipReset);

  always #10 mclk = ~mclk;
  // slow source clock: one tick every eight cycles
  always @(posedge mclk) begin
    wdtDiv <= wdtDiv + 3'h1;
    wdtSourceClock <= wdtDiv[2];
    if (irqServe === 1'b1) nServe++;
    if (resumeAfterHalt === 1'b1) nResume++;
    if (pcSpReset === 1'b1) nPcSp++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {27'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // no local limit: only the bench watchdog ends a hung transfer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic waitHi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge mclk);
  endtask

  task automatic doHalt();
    @(posedge mclk);
    haltExec <= 1;
    @(posedge mclk);
    haltExec <= 0;
    repeat (3) @(posedge mclk);
    check(cpuRun, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    apb(0, PMW_OSCCTL_ADDR, 0);
    check(rd, 32'h3);
    apb(0, PMW_WDTCTL_ADDR, 0);
    check(rd, 32'hB);
    apb(0, PMW_STATUS_ADDR, 0);
    check(rd, 32'h0);
    apb(0, 5'h14, 0);
    check(rd, 32'h0);
    check(err, 1'b1);
    check(sysClkSelect, PMW_SEL_RST);
    apb(1, PMW_WDTCTL_ADDR, 0);
    $display("test reset done");
  endtask

  task automatic testModes();
    logic [2:0] mode [4] = '{PMW_MODE_SLEEP, PMW_MODE_IDLE_SUB_ONLY, PMW_MODE_IDLE_HS_ONLY, PMW_MODE_IDLE_BOTH_CLOCKS};
    apb(1, PMW_WAKEEN_ADDR, 32'h8);
    for (int k = 0; k < 4; k++) begin
      apb(1, PMW_SYSCTL_ADDR, 32'(k));
      doHalt();
      check({highSpeedOscEn, lowSpeedOscEn, subClkEn}, {k[1], k[0], k[0]});
      apb(0, PMW_STATUS_ADDR, 0);
      check(rd, (32'(mode[k]) << PMW_MODE_LSB) | 32'h1);
      apb(0, PMW_SYSCTL_ADDR, 0);
      check(rd, 32'(k));
      portAPin <= 8'hFE;
      repeat (8) @(posedge mclk);
      check(cpuRun, 0);
      portAPin <= 8'hF6;
      waitHi(resumeAfterHalt, 20);
      check(resumeAfterHalt, 1);
      waitHi(cpuRun, 20);
      check(cpuRun, 1);
      portAPin <= 8'hFF;
    end
    $display("test modes done");
  endtask

  task automatic testIrq();
    int s = nServe;
    int r = nResume;
    irqRequest <= 8'h01;
    irqEnable <= 8'h03;
    doHalt();
    repeat (10) @(posedge mclk);
    check(cpuRun, 0);
    irqRequest <= 8'h03;
    waitHi(cpuRun, 30);
    check(nServe - s, 1);
    check(nResume - r, 0);
    irqRequest <= 8'h00;
    stackFull <= 1;
    doHalt();
    irqRequest <= 8'h02;
    waitHi(cpuRun, 30);
    check(nServe - s, 1);
    check(nResume - r, 1);
    irqRequest <= 8'h00;
    stackFull <= 0;
    $display("test interrupt done");
  endtask

  task automatic testWdt();
    int p = nPcSp;
    // both keep bits 0: true sleep, only the watchdog clock may run
    apb(1, PMW_SYSCTL_ADDR, 0);
    apb(1, PMW_WDTCTL_ADDR, 32'h8);
    doHalt();
    check(lowSpeedOscEn, 1);
    check(subClkEn, 0);
    // shortest period: 2^8 ticks of eight cycles each
    waitHi(cpuRun, 2400);
    check(nPcSp - p, 1);
    apb(1, PMW_WDTCTL_ADDR, 0);
    apb(0, PMW_STATUS_ADDR, 0);
    check(rd[1:0], 2'h3);
    @(posedge mclk);
    clearWatchdogInstruction <= 1;
    @(posedge mclk);
    clearWatchdogInstruction <= 0;
    apb(0, PMW_STATUS_ADDR, 0);
    check(rd[1:0], 2'h2);
    // overflow while running is a chip reset, not the halted pc/stack reset
    apb(1, PMW_WDTCTL_ADDR, 32'h8);
    waitHi(wdtChipReset, 2400);
    check(wdtChipReset, 1);
    check(nPcSp - p, 1);
    apb(1, PMW_WDTCTL_ADDR, 0);
    $display("test watchdog done");
  endtask

  task automatic testSwitch();
    lowSpeedOscReady <= 0;
    apb(1, PMW_SYSCTL_ADDR, 32'h7 << PMW_SEL_LSB);
    repeat (10) @(posedge mclk);
    check(sysClkSelect, 0);
    // time-out still set from the watchdog test, power-down cleared
    apb(0, PMW_STATUS_ADDR, 0);
    check(rd, (32'(PMW_MODE_SWITCH) << PMW_MODE_LSB) | 32'h2);
    lowSpeedOscReady <= 1;
    for (int i = 0; i < 20 && sysClkSelect !== 3'h7; i++) @(posedge mclk);
    check(sysClkSelect, PMW_SEL_SUB);
    apb(0, PMW_STATUS_ADDR, 0);
    check(rd, (32'(PMW_MODE_SLOW) << PMW_MODE_LSB) | 32'h2);
    apb(1, PMW_OSCCTL_ADDR, 0);
    highSpeedOscReady <= 0;
    apb(1, PMW_OSCCTL_ADDR, 1);
    apb(0, PMW_OSCCTL_ADDR, 0);
    check(rd, 32'h1);
    apb(1, PMW_SYSCTL_ADDR, 32'h2 << PMW_SEL_LSB);
    repeat (10) @(posedge mclk);
    check(sysClkSelect, PMW_SEL_SUB);
    highSpeedOscReady <= 1;
    for (int i = 0; i < 20 && sysClkSelect !== 3'h2; i++) @(posedge mclk);
    check(sysClkSelect, 3'h2);
    apb(0, PMW_OSCCTL_ADDR, 0);
    check(rd, 32'h3);
    $display("test switch done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 0;
    testReset();
    testModes();
    testIrq();
    testWdt();
    testSwitch();
    stopTest();
  end

  initial begin
    #200000;
    badCount++;
    stopTest();
  end
endmodule
